/* File: core/lsu_params.svh */
// offsets, field positions, reset values and limits of the logical shift unit
// Behaviour
// RQ1: word shift left moves only low half of accumulator left, zero fill.
// RQ2: word shift right moves only low half right, zero fill, upper half kept.
// RQ3: double-word shift left moves all 32 bits left, zeros enter low end.
// RQ4: double-word shift right moves all 32 bits right, zeros enter high end.
// RQ5: nonzero shift puts last bit pushed out into condition code one.
// RQ6: count comes from immediate when present, else from accumulator 2 low byte.
// RQ7: caller keeps immediate word shift counts within 0 to 15.
// RQ8: caller keeps immediate double-word shift counts within 0 to 32.
// RQ9: immediate count above zero clears condition code zero and overflow.
// RQ10: zero count is a no-operation: accumulator and status untouched.
// RQ11: register count accepts any 8-bit value 0 to 255.
// RQ12: word shift count above 16 zeroes low half, clears both codes and overflow.
// RQ13: double-word count above 32 zeroes accumulator, clears both codes and overflow.
// RQ14: register count 1..limit clears condition code zero and overflow.
// RQ15: shifts are unconditional and leave all other status bits unchanged.
// RQ16: only low byte of accumulator 2 supplies the count, higher bits ignored.
// RQ17: whole shift and status update complete in one step by barrel shifter.
`ifndef LSU_PARAMS_SVH
`define LSU_PARAMS_SVH

// register byte offsets
`define LSU_ACC1_OFS 8'h00
`define LSU_ACC2_OFS 8'h04
`define LSU_STATUS_OFS 8'h08
`define LSU_CMD_OFS 8'h0c
`define LSU_INFO_OFS 8'h10

// reset values
`define LSU_ACC_RST 32'h0000_0000
`define LSU_STATUS_RST 9'h000

// field limits
`define LSU_WORD_BITS 16
`define LSU_DWORD_BITS 32
`define LSU_WORD_LIMIT 8'h10
`define LSU_DWORD_LIMIT 8'h20
`define LSU_STATUS_BITS 9

// info register field positions
`define LSU_INFO_OP_LSB 8
`define LSU_INFO_SAT_BIT 12
`define LSU_INFO_NOP_BIT 13

`endif

/* File: core/lsu_pkg.sv */
// types shared by the logical shift unit
package lsu_pkg;

  // shift operation selector
  typedef enum logic [1:0] {
    word_shift_left_op = 2'h0,
    word_shift_right_op = 2'h1,
    dword_shift_left_op = 2'h2,
    dword_shift_right_op = 2'h3
  } shift_op_e;

  // command word as written by software
  typedef struct packed {
    logic [15:0] unused_hi;
    logic [7:0] imm_count;
    logic [2:0] unused_mid;
    logic imm_valid;
    logic [1:0] unused_lo;
    shift_op_e op;
  } cmd_s;

  // status word, bit 8 down to bit 0
  typedef struct packed {
    logic binary_result;
    logic condition_code_one;
    logic condition_code_zero;
    logic overflow_flag;
    logic stored_overflow;
    logic or_bit;
    logic status_bit;
    logic logic_result_bit;
    logic first_check;
  } status_s;

endpackage

/* File: core/barrel_shift.sv */
// one-step zero-fill barrel shifter with last-bit-out
`timescale 1ns/10ps
module barrel_shift #(
  parameter int W = 16,
  parameter int CW = $clog2(W + 1)
) (
  input wire logic [W-1:0] data,
  input wire logic [CW-1:0] count,
  input wire logic left,
  output logic [W-1:0] result,
  output logic out_bit
);

  // one extra bit catches whatever leaves the field last; count may equal W
  always_comb begin
    logic [W:0] ext;
    ext = '0;
    if (left) begin
      ext = {1'b0, data} << count; // RQ17
      result = ext[W-1:0];
      out_bit = ext[W];
    end else begin
      ext = {data, 1'b0} >> count; // RQ17
      result = ext[W:1];
      out_bit = ext[0];
    end
  end

endmodule

/* File: core/logical_shift_unit.sv */
// logical shift unit with its accumulators and status word behind an apb slave
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "lsu_params.svh"
module logical_shift_unit
  import lsu_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] primary_accumulator,
  output logic condition_code_one
);

  logic [31:0] acc2;
  status_s status;
  logic [7:0] last_count;
  shift_op_e last_op;
  logic last_sat;
  logic last_nop;

  logic setup;
  logic access;
  logic hit_acc1;
  logic hit_acc2;
  logic hit_status;
  logic hit_cmd;
  logic hit_info;
  logic mapped;
  logic exec;
  cmd_s cmd;

  logic [7:0] eff_count;
  logic is_word;
  logic saturate;
  logic [15:0] word_res;
  logic word_out;
  logic [31:0] dword_res;
  logic dword_out;
  logic [31:0] next_acc1;
  status_s next_status;
  logic [31:0] status_wr;

  // apb phase decode
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit_acc1 = (paddr[7:0] == `LSU_ACC1_OFS);
  assign hit_acc2 = (paddr[7:0] == `LSU_ACC2_OFS);
  assign hit_status = (paddr[7:0] == `LSU_STATUS_OFS);
  assign hit_cmd = (paddr[7:0] == `LSU_CMD_OFS);
  assign hit_info = (paddr[7:0] == `LSU_INFO_OFS);
  assign mapped = hit_acc1 | hit_acc2 | hit_status | hit_cmd | hit_info;

  // zero wait states: every access phase completes at its first edge
  assign pready = penable;

  // a command write executes the shift at the completing edge
  assign exec = access & pwrite & hit_cmd;
  assign cmd = cmd_s'(pwdata);

  // merge write data by byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // count source: immediate if the command carries one, else the low byte only
  assign eff_count = cmd.imm_valid ? cmd.imm_count : acc2[7:0]; // RQ6 RQ16 RQ11
  assign is_word = (cmd.op == word_shift_left_op) | (cmd.op == word_shift_right_op);

  // counts past the field width give the same result as exactly the width plus one
  // an immediate beyond its range is treated the same way rather than wrapped
  assign saturate = is_word ? (eff_count > `LSU_WORD_LIMIT) : (eff_count > `LSU_DWORD_LIMIT); // RQ12 RQ13

  // 16-bit shifter on the low half only
  barrel_shift #(
    .W(`LSU_WORD_BITS)
  ) u_word (
    .data(primary_accumulator[15:0]),
    .count(eff_count[4:0]),
    .left(cmd.op == word_shift_left_op),
    .result(word_res),
    .out_bit(word_out)
  );

  // 32-bit shifter on the whole accumulator
  barrel_shift #(
    .W(`LSU_DWORD_BITS)
  ) u_dword (
    .data(primary_accumulator),
    .count(eff_count[5:0]),
    .left(cmd.op == dword_shift_left_op),
    .result(dword_res),
    .out_bit(dword_out)
  );

  // next accumulator: zero count holds, saturation clears the shifted field
  always_comb begin
    next_acc1 = primary_accumulator;
    if (eff_count == 8'h00) begin
      next_acc1 = primary_accumulator; // RQ10
    end else if (saturate) begin
      if (is_word) begin
        next_acc1 = {primary_accumulator[31:16], 16'h0000}; // RQ12
      end else begin
        next_acc1 = 32'h0000_0000; // RQ13
      end
    end else if (is_word) begin
      next_acc1 = {primary_accumulator[31:16], word_res}; // RQ1 RQ2
    end else begin
      next_acc1 = dword_res; // RQ3 RQ4
    end
  end

  // next status: only the two codes and overflow may move
  always_comb begin
    next_status = status; // RQ15
    if (eff_count != 8'h00) begin
      next_status.condition_code_zero = 1'b0; // RQ9 RQ14
      next_status.overflow_flag = 1'b0; // RQ9 RQ14
      if (saturate) begin
        next_status.condition_code_one = 1'b0; // RQ12 RQ13
      end else begin
        next_status.condition_code_one = is_word ? word_out : dword_out; // RQ5
      end
    end
  end

  // primary accumulator: software write or shift result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_accumulator <= `LSU_ACC_RST;
    end else if (access & pwrite & hit_acc1) begin
      primary_accumulator <= merge(primary_accumulator, pwdata, pstrb);
    end else if (exec) begin
      primary_accumulator <= next_acc1; // RQ17
    end
  end

  // secondary accumulator, read by the shifter and over the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc2 <= `LSU_ACC_RST;
    end else if (access & pwrite & hit_acc2) begin
      acc2 <= merge(acc2, pwdata, pstrb);
    end
  end

  // status write merged on the full word, then cut to the nine bits that exist
  assign status_wr = merge({23'h000000, status}, pwdata, pstrb);

  // status word: software may load it, a shift updates three bits of it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= status_s'(`LSU_STATUS_RST);
    end else if (access & pwrite & hit_status) begin
      status <= status_wr[8:0];
    end else if (exec) begin
      status <= next_status; // RQ17
    end
  end

  assign condition_code_one = status.condition_code_one;

  // record of the last executed shift for software to inspect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_count <= 8'h00;
      last_op <= word_shift_left_op;
      last_sat <= 1'b0;
      last_nop <= 1'b0;
    end else if (exec) begin
      last_count <= eff_count;
      last_op <= cmd.op;
      last_sat <= saturate & (eff_count != 8'h00);
      last_nop <= (eff_count == 8'h00);
    end
  end

  // read data and error are captured in the setup cycle so they leave flops
  // safe because nothing but the bus itself changes the registers in between
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~mapped;
      prdata <= 32'h0000_0000;
      if (!pwrite) begin
        if (hit_acc1) begin
          prdata <= primary_accumulator;
        end else if (hit_acc2) begin
          prdata <= acc2;
        end else if (hit_status) begin
          prdata <= {23'h000000, status};
        end else if (hit_info) begin
          prdata[7:0] <= last_count;
          prdata[`LSU_INFO_OP_LSB +: 2] <= last_op;
          prdata[`LSU_INFO_SAT_BIT] <= last_sat;
          prdata[`LSU_INFO_NOP_BIT] <= last_nop;
        end
      end
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  // checks on the shift behaviour
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_exec_any;
    exec;
  endsequence

  sequence s_exec_word;
    exec && is_word;
  endsequence

  sequence s_exec_shift;
    exec && (eff_count != 8'h00) && !saturate;
  endsequence

  sequence s_count_one;
    exec && (eff_count == 8'h01);
  endsequence

  sequence s_count_full;
    exec && (eff_count == (is_word ? `LSU_WORD_LIMIT : `LSU_DWORD_LIMIT));
  endsequence

  a_word_upper_kept: assert property (s_exec_word |=> // RQ1
    primary_accumulator[31:16] == $past(primary_accumulator[31:16]))
    else $error("word shift changed upper half");

  a_word_right_fill: assert property (s_exec_shift ##0 (cmd.op == word_shift_right_op) |=> // RQ2
    primary_accumulator[15] == 1'b0)
    else $error("word right shift did not zero fill");

  a_dword_left_fill: assert property (s_exec_shift ##0 (cmd.op == dword_shift_left_op) |=> // RQ3
    primary_accumulator[0] == 1'b0)
    else $error("dword left shift did not zero fill");

  a_dword_right_fill: assert property (s_exec_shift ##0 (cmd.op == dword_shift_right_op) |=> // RQ4
    primary_accumulator[31] == 1'b0 && ($past(eff_count) != 8'h01 ||
    primary_accumulator[30:0] == $past(primary_accumulator[31:1])))
    else $error("dword right shift by one wrong");

  a_last_bit_out: assert property (s_exec_shift ##0 (cmd.op == dword_shift_right_op) ##0 // RQ5
    (eff_count == 8'h01) |=>
    condition_code_one == $past(primary_accumulator[0]))
    else $error("last bit out not in condition code one");

  a_word_left_fill: assert property (s_exec_shift ##0 (cmd.op == word_shift_left_op) |=> // RQ1
    primary_accumulator[0] == 1'b0)
    else $error("word left shift did not zero fill");

  a_word_left_one: assert property (s_count_one ##0 (cmd.op == word_shift_left_op) |=> // RQ1
    primary_accumulator[15:0] == {$past(primary_accumulator[14:0]), 1'b0})
    else $error("word left shift by one wrong");

  a_word_right_one: assert property (s_count_one ##0 (cmd.op == word_shift_right_op) |=> // RQ2
    primary_accumulator[15:0] == {1'b0, $past(primary_accumulator[15:1])})
    else $error("word right shift by one wrong");

  a_dword_left_one: assert property (s_count_one ##0 (cmd.op == dword_shift_left_op) |=> // RQ3
    primary_accumulator == {$past(primary_accumulator[30:0]), 1'b0})
    else $error("dword left shift by one wrong");

  a_word_left_out: assert property (s_count_one ##0 (cmd.op == word_shift_left_op) |=> // RQ5
    condition_code_one == $past(primary_accumulator[15]))
    else $error("word left shift lost the bit pushed out");

  a_word_right_out: assert property (s_count_one ##0 (cmd.op == word_shift_right_op) |=> // RQ5
    condition_code_one == $past(primary_accumulator[0]))
    else $error("word right shift lost the bit pushed out");

  a_dword_left_out: assert property (s_count_one ##0 (cmd.op == dword_shift_left_op) |=> // RQ5
    condition_code_one == $past(primary_accumulator[31]))
    else $error("dword left shift lost the bit pushed out");

  a_full_left_out: assert property (s_count_full ##0 !cmd.op[0] |=> // RQ5
    condition_code_one == $past(primary_accumulator[0]) && primary_accumulator[15:0] == 16'h0000)
    else $error("full width left shift wrong");

  a_full_word_right: assert property (s_count_full ##0 (cmd.op == word_shift_right_op) |=> // RQ5
    condition_code_one == $past(primary_accumulator[15]) && primary_accumulator[15:0] == 16'h0000)
    else $error("full width word right shift wrong");

  a_full_dword_right: assert property (s_count_full ##0 (cmd.op == dword_shift_right_op) |=> // RQ5
    condition_code_one == $past(primary_accumulator[31]) && primary_accumulator == 32'h0000_0000)
    else $error("full width dword right shift wrong");

  a_imm_clears_flags: assert property (s_exec_any ##0 cmd.imm_valid ##0 (cmd.imm_count != 8'h00) |=> // RQ9
    !status.condition_code_zero && !status.overflow_flag)
    else $error("immediate shift left code zero or overflow set");

  a_zero_is_nop: assert property (s_exec_any ##0 (eff_count == 8'h00) |=> // RQ10
    $stable(primary_accumulator) && $stable(status))
    else $error("zero count shift changed state");

  a_word_saturate: assert property (s_exec_word ##0 !cmd.imm_valid ##0 (acc2[7:0] > 8'h10) |=> // RQ12
    primary_accumulator[15:0] == 16'h0000 && !status.condition_code_one &&
    !status.condition_code_zero && !status.overflow_flag)
    else $error("word saturation wrong");

  a_dword_saturate: assert property (s_exec_any ##0 !is_word ##0 !cmd.imm_valid ##0 (acc2[7:0] > 8'h20) |=> // RQ13
    primary_accumulator == 32'h0000_0000 && !status.condition_code_one &&
    !status.condition_code_zero && !status.overflow_flag)
    else $error("dword saturation wrong");

  a_reg_count_flags: assert property (s_exec_shift ##0 !cmd.imm_valid |=> // RQ14
    !status.condition_code_zero && !status.overflow_flag)
    else $error("register count shift left flags set");

  a_other_bits_kept: assert property (s_exec_any |=> // RQ15
    status.binary_result == $past(status.binary_result) && status[4:0] == $past(status[4:0]))
    else $error("shift touched unrelated status bits");

  a_count_low_byte: assert property (s_exec_any ##0 !cmd.imm_valid ##0 (acc2[7:0] == 8'h00) ##0 // RQ16
    (acc2[31:8] != 24'h0) |=>
    $stable(primary_accumulator))
    else $error("upper accumulator 2 bits used as count");

  a_one_step_done: assert property (s_exec_shift |=> // RQ17
    primary_accumulator == $past(next_acc1) && status == $past(next_status))
    else $error("shift not complete in one step");

endmodule

/* File: bench/shift_host.sv */
// apb master model standing in for the instruction decoder
`timescale 1ns/10ps
module shift_host (
  input wire logic pclk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
  end

  // one transfer; released lines flip so stale data never looks valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

/* File: bench/tb.sv */
// self-checking bench for the logical shift unit
`timescale 1ns/10ps
`include "lsu_params.svh"
module tb;
  import lsu_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, condition_code_one;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, primary_accumulator;
  logic [3:0] pstrb;
  logic [32:0] exp_q[$];
  int n_errors = 0;
  int checks = 0;
  logic [31:0] seed = 32'h0000002c;

  logical_shift_unit #(.ADDR_W(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .primary_accumulator(primary_accumulator), .condition_code_one(condition_code_one));
  shift_host i_host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [32:0] seen, input logic [32:0] expd, input string what);
    checks++;
    if (seen !== expd) begin
      n_errors++;
      $display("CHECK FAILED %0t %s seen %h expected %h", $time, what, seen, expd);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // read results are judged when they appear on the bus
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) chk(33'h0, 33'h1, "unexpected read");
      else chk({pslverr, prdata}, exp_q.pop_front(), "read");
    end
  end

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    i_host.xfer(1'b0, a, 32'h0);
  endtask

  // one shift: predict, load registers, fire the command and compare
  task automatic run(input shift_op_e op, input logic iv, input logic [7:0] imm, input logic [31:0] a1,
                     input logic [31:0] a2, input logic [8:0] st);
    logic [7:0] cnt;
    logic [63:0] t;
    logic [31:0] f, res;
    status_s s;
    int w;
    cmd_s c;
    logic [31:0] inf;
    c = '0;
    c.op = op;
    c.imm_valid = iv;
    c.imm_count = imm;
    cnt = iv ? imm : a2[7:0];
    w = op[1] ? 32 : 16;
    f = op[1] ? a1 : {16'h0, a1[15:0]};
    s = st;
    res = a1;
    // zero-extended wide shift covers saturation without a special case
    if (cnt != 8'h00) begin
      if (!op[0]) begin
        t = {32'h0, f} << cnt;
        s.condition_code_one = t[w];
        res = t[31:0];
      end else begin
        t = {f, 32'h0} >> cnt;
        s.condition_code_one = t[31];
        res = t[63:32];
      end
      if (!op[1]) res = {a1[31:16], res[15:0]};
      s.condition_code_zero = 1'b0;
      s.overflow_flag = 1'b0;
    end
    i_host.xfer(1'b1, `LSU_ACC1_OFS, a1);
    i_host.xfer(1'b1, `LSU_ACC2_OFS, a2);
    i_host.xfer(1'b1, `LSU_STATUS_OFS, {23'h0, st});
    i_host.xfer(1'b1, `LSU_CMD_OFS, c);
    #1;
    chk({1'b0, primary_accumulator}, {1'b0, res}, "acc port");
    chk({32'h0, condition_code_one}, {32'h0, s.condition_code_one}, "cc1 port");
    rd(`LSU_ACC1_OFS, {1'b0, res});
    rd(`LSU_STATUS_OFS, {24'h0, s});
    // record of the last shift: count, op, saturation and zero-count flags
    inf = 32'h0;
    inf[7:0] = cnt;
    inf[`LSU_INFO_OP_LSB +: 2] = op;
    inf[`LSU_INFO_SAT_BIT] = cnt > (op[1] ? `LSU_DWORD_LIMIT : `LSU_WORD_LIMIT);
    inf[`LSU_INFO_NOP_BIT] = (cnt == 8'h00);
    rd(`LSU_INFO_OFS, {1'b0, inf});
  endtask

  initial begin
    logic [7:0] cv[8];
    logic [7:0] lim, imx;
    logic [31:0] r;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`LSU_ACC1_OFS, 33'h0);
    rd(`LSU_STATUS_OFS, 33'h0);
    // per op: immediate 0, 5, top of range, then register counts at the edges
    for (int o = 0; o < 4; o++) begin
      lim = o[1] ? 8'h20 : 8'h10;
      imx = o[1] ? 8'h20 : 8'h0f;
      cv = '{8'h00, 8'h05, imx, 8'h00, 8'h01, lim, lim + 8'h01, 8'hff};
      for (int k = 0; k < 8; k++) begin
        r = rnd();
        run(shift_op_e'(o[1:0]), k < 3, cv[k], rnd(), (k < 3) ? r : {r[31:8], cv[k]}, r[8:0]);
      end
      $display("test op %0d done", o);
    end
    // unmapped place and write-only command word
    rd(8'h14, {1'b1, 32'h0});
    rd(`LSU_CMD_OFS, 33'h0);
    $display("test bus done");
    stop_test();
  end

  // watchdog well past the roughly 700 cycles the tests need
  initial begin
    #200000;
    n_errors++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    stop_test();
  end
endmodule
